// >>> design/chg_bus_sync.sv
// pin synchroniser and bus event detector for clock and data lines
`timescale 1ns/1ps
module chg_bus_sync (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_scl,
	input wire logic i_sda,
	output chg_pkg::chg_bus_ev_t o_ev
);
	import chg_pkg::*;
	logic [1:0] s1_reg;
	logic [1:0] s2_reg;
	logic [1:0] s3_reg;
	// s1 only feeds s2; edges are found between s2 and s3
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			s1_reg <= 2'h3;
			s2_reg <= 2'h3;
			s3_reg <= 2'h3;
		end else begin
			s1_reg <= {i_scl, i_sda};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	assign o_ev.scl = s2_reg[1];
	assign o_ev.sda = s2_reg[0];
	assign o_ev.scl_rise = s2_reg[1] && !s3_reg[1];
	assign o_ev.scl_fall = !s2_reg[1] && s3_reg[1];
	assign o_ev.start = s2_reg[1] && s3_reg[1] && s3_reg[0] && !s2_reg[0];
	assign o_ev.stop = s2_reg[1] && s3_reg[1] && !s3_reg[0] && s2_reg[0];
endmodule

// >>> design/chg_cfg.svh
// constants of the charger two-wire slave
`ifndef CHG_CFG_SVH
`define CHG_CFG_SVH
`define CHG_CLK_PERIOD_NS 10
`define CHG_PWM_PERIOD_NS 4000
`define CHG_PWM_CYCLES (`CHG_PWM_PERIOD_NS / `CHG_CLK_PERIOD_NS)
`define CHG_SLAVE_ADDR 7'h09
`define CHG_ADDR_WRITE 8'h12
`define CHG_ADDR_READ 8'h13
`define CHG_CMD_MODE 8'h12
`define CHG_CMD_STATUS 8'h13
`define CHG_CMD_CURR 8'h14
`define CHG_CMD_VOLT 8'h15
`define CHG_CMD_ALARM 8'h16
`define CHG_MODE_RST 16'hFFD0
`define CHG_VOLT_RST 16'h47F0
`define CHG_CURR_RST 16'h0007
`define CHG_VOLT_FULL 16'hFFF0
`define CHG_VOLT_MASK 16'hFFF0
`define CHG_MODE_POR_BIT 2
`define CHG_MODE_TSTOP_BIT 10
`define CHG_STAT_BATT_BIT 14
`define CHG_STAT_ALARM_BIT 3
`endif

// >>> design/chg_pkg.sv
// types shared by the charger two-wire slave
package chg_pkg;
	typedef struct packed {
		logic scl;
		logic sda;
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
	} chg_bus_ev_t;
	typedef struct packed {
		logic [15:0] mode;
		logic [15:0] volt;
		logic [15:0] curr;
	} chg_setpoints_t;
	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_CMD, ST_WLO, ST_WHI, ST_RADR, ST_TX_LO, ST_TX_HI, ST_DONE
	} chg_state_t;
endpackage

// >>> design/chg_smbus_slave.sv
// charger two-wire slave: word protocols, setpoints, status and converter timing
//
// Behaviour
// - slave only; never starts a transfer, only answers the master
// - each byte is eight bits plus one acknowledge, nine clocks
// - data line changes only while clock low, except start and stop
// - answer only to fixed 7-bit address 0001001
// - eighth address bit: 0 write word, 1 read word
// - address, then command, then data, between start and stop
// - setpoint, mode and alarm only by write; status only by read
// - command 12h writes mode word, bit 0 is data bit 0
// - battery absent forces thermal stop mode bit to one
// - converter switches at fixed 250 kHz, duty modulated
// - synchronous rectifier off once inductor current reaches zero
// - command 13h returns the 16-bit status word by read
// - command 15h loads voltage setpoint, low four bits ignored
// - command 14h loads current setpoint by write
// - command 16h sets the alarm inhibited status bit
`timescale 1ns/1ps
`include "chg_cfg.svh"
module chg_smbus_slave (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic [15:0] i_status,
	input wire logic [8:0] i_duty,
	input wire logic i_zero_current,
	output logic o_sda,
	output logic o_sda_oe,
	output chg_pkg::chg_setpoints_t o_set,
	output logic o_alarm_inh,
	output logic o_hs_gate,
	output logic o_ls_gate
);
	import chg_pkg::*;
	chg_bus_ev_t ev;
	chg_state_t state_reg;
	chg_setpoints_t set_next;
	logic [3:0] cnt_reg;
	logic ack_reg;
	logic [7:0] shift_reg;
	logic [7:0] cmd_reg;
	logic [7:0] hold_reg;
	logic [7:0] tx_reg;
	logic [15:0] stat_s1_reg;
	logic [15:0] stat_s2_reg;
	logic zero_s1_reg;
	logic zero_s2_reg;
	logic zero_seen_reg;
	logic alarm_next;
	logic [8:0] pwm_cnt_reg;

	chg_bus_sync u_sync (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_scl(i_scl),
		.i_sda(i_sda),
		.o_ev(ev)
	);

	// analog status pins are asynchronous to this clock
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			stat_s1_reg <= 16'h0000;
			stat_s2_reg <= 16'h0000;
			zero_s1_reg <= 1'b0;
			zero_s2_reg <= 1'b0;
		end else begin
			stat_s1_reg <= i_status;
			stat_s2_reg <= stat_s1_reg;
			zero_s1_reg <= i_zero_current;
			zero_s2_reg <= zero_s1_reg;
		end
	end

	wire batt = stat_s2_reg[`CHG_STAT_BATT_BIT];
	wire [15:0] status_word = {stat_s2_reg[15:`CHG_STAT_ALARM_BIT + 1], o_alarm_inh,
		stat_s2_reg[`CHG_STAT_ALARM_BIT - 1:0]};
	wire byte_end = ev.scl_fall && !ack_reg && cnt_reg == 4'h8;
	wire ack_end = ev.scl_fall && ack_reg;
	wire addr_hit = shift_reg[7:1] == `CHG_SLAVE_ADDR;
	wire is_read = shift_reg[0];
	wire rd_ok = cmd_reg == `CHG_CMD_STATUS;
	wire tx_state = state_reg == ST_TX_LO || state_reg == ST_TX_HI;
	wire commit = byte_end && state_reg == ST_WHI;
	wire [15:0] wdata = {shift_reg, hold_reg};

	// byte engine; line only ever released or pulled, never started by us
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 4'h0;
			ack_reg <= 1'b0;
			shift_reg <= 8'h00;
			cmd_reg <= 8'h00;
			hold_reg <= 8'h00;
			tx_reg <= 8'h00;
			o_sda <= 1'b0;
			o_sda_oe <= 1'b1;
		end else if (ev.start) begin
			state_reg <= ST_ADDR;
			cnt_reg <= 4'h0;
			ack_reg <= 1'b0;
			o_sda_oe <= 1'b1;
		end else if (ev.stop) begin
			state_reg <= ST_IDLE;
			ack_reg <= 1'b0;
			o_sda_oe <= 1'b1;
		end else if (state_reg == ST_IDLE) begin
			cnt_reg <= 4'h0;
		end else if (ev.scl_rise) begin
			if (!ack_reg && cnt_reg < 4'h8) begin
				shift_reg <= {shift_reg[6:0], ev.sda};
				cnt_reg <= cnt_reg + 4'h1;
			end else if (ack_reg && tx_state && ev.sda) begin
				state_reg <= ST_DONE;
			end
		end else if (byte_end) begin
			ack_reg <= 1'b1;
			o_sda_oe <= 1'b1;
			case (state_reg)
				ST_ADDR: begin
					if (addr_hit && !is_read) begin
						o_sda_oe <= 1'b0;
						state_reg <= ST_CMD;
					end else if (addr_hit && rd_ok) begin
						o_sda_oe <= 1'b0;
						state_reg <= ST_RADR;
					end else begin
						state_reg <= ST_DONE;
					end
				end
				ST_CMD: begin
					cmd_reg <= shift_reg;
					o_sda_oe <= 1'b0;
					state_reg <= ST_WLO;
				end
				ST_WLO: begin
					hold_reg <= shift_reg;
					o_sda_oe <= 1'b0;
					state_reg <= ST_WHI;
				end
				ST_WHI: begin
					o_sda_oe <= 1'b0;
					state_reg <= ST_DONE;
				end
				ST_TX_LO, ST_TX_HI: begin
					o_sda_oe <= 1'b1;
				end
				default: begin
					state_reg <= ST_DONE;
				end
			endcase
		end else if (ack_end) begin
			// status latched at read start so both bytes come from one sample
			ack_reg <= 1'b0;
			cnt_reg <= 4'h0;
			case (state_reg)
				ST_RADR: begin
					tx_reg <= {status_word[6:0], 1'b0};
					hold_reg <= status_word[15:8];
					o_sda_oe <= status_word[7];
					state_reg <= ST_TX_LO;
				end
				ST_TX_LO: begin
					tx_reg <= {hold_reg[6:0], 1'b0};
					o_sda_oe <= hold_reg[7];
					state_reg <= ST_TX_HI;
				end
				ST_TX_HI: begin
					o_sda_oe <= 1'b1;
					state_reg <= ST_DONE;
				end
				default: begin
					o_sda_oe <= 1'b1;
				end
			endcase
		end else if (ev.scl_fall && tx_state && !ack_reg) begin
			o_sda_oe <= tx_reg[7];
			tx_reg <= {tx_reg[6:0], 1'b0};
		end
	end

	// setpoint and mode update; battery removal overrides setpoint and alarm writes and the thermal stop mode bit
	always_comb begin
		set_next = o_set;
		alarm_next = o_alarm_inh;
		if (commit) begin
			case (cmd_reg)
				`CHG_CMD_MODE: begin
					set_next.mode = wdata;
					if (wdata[`CHG_MODE_POR_BIT]) begin
						set_next.volt = `CHG_VOLT_FULL;
						set_next.curr = `CHG_CURR_RST;
						alarm_next = 1'b0;
					end
				end
				`CHG_CMD_VOLT: begin
					set_next.volt = wdata & `CHG_VOLT_MASK;
					alarm_next = 1'b0;
				end
				`CHG_CMD_CURR: begin
					set_next.curr = wdata;
					alarm_next = 1'b0;
				end
				`CHG_CMD_ALARM: begin
					alarm_next = 1'b1;
				end
				default: begin
					alarm_next = o_alarm_inh;
				end
			endcase
		end
		if (!batt) begin
			set_next.mode[`CHG_MODE_TSTOP_BIT] = 1'b1;
			set_next.volt = `CHG_VOLT_RST;
			set_next.curr = `CHG_CURR_RST;
			alarm_next = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_set <= {`CHG_MODE_RST, `CHG_VOLT_RST, `CHG_CURR_RST};
			o_alarm_inh <= 1'b0;
		end else begin
			o_set <= set_next;
			o_alarm_inh <= alarm_next;
		end
	end

	// converter timing: fixed period, duty from the error loop
	wire pwm_tick = pwm_cnt_reg == 9'(`CHG_PWM_CYCLES - 1);
	wire hs_on = pwm_cnt_reg < i_duty;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			pwm_cnt_reg <= 9'h000;
			zero_seen_reg <= 1'b0;
			o_hs_gate <= 1'b0;
			o_ls_gate <= 1'b0;
		end else begin
			pwm_cnt_reg <= pwm_tick ? 9'h000 : pwm_cnt_reg + 9'h001;
			zero_seen_reg <= !pwm_tick && (zero_seen_reg || zero_s2_reg);
			o_hs_gate <= hs_on;
			o_ls_gate <= !hs_on && !zero_seen_reg && !zero_s2_reg;
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_srst);

	sequence s_own_write_addr;
		byte_end && state_reg == ST_ADDR && shift_reg == `CHG_ADDR_WRITE;
	endsequence
	sequence s_foreign_addr;
		byte_end && state_reg == ST_ADDR && !addr_hit;
	endsequence
	sequence s_mode_commit;
		commit && cmd_reg == `CHG_CMD_MODE && batt && !wdata[`CHG_MODE_POR_BIT];
	endsequence

	AST_IDLE_RELEASED: assert property (state_reg == ST_IDLE |-> o_sda_oe)
		else $error("line pulled while idle");
	AST_ACK_OWN_ADDR: assert property (s_own_write_addr ##1 !ev.start && !ev.stop |-> !o_sda_oe)
		else $error("own write address not acknowledged");
	AST_IGNORE_FOREIGN: assert property (s_foreign_addr |=> o_sda_oe && state_reg == ST_DONE)
		else $error("foreign address answered");
	AST_CHANGE_CLOCK_LOW: assert property ($changed(o_sda_oe) |-> !ev.scl)
		else $error("data line moved while clock high");
	AST_THERMAL_FORCE: assert property (!batt |=> o_set.mode[`CHG_MODE_TSTOP_BIT] && o_set.curr == `CHG_CURR_RST)
		else $error("thermal stop not forced with battery absent");
	AST_MODE_LOAD: assert property (s_mode_commit |=> o_set.mode == $past(wdata))
		else $error("mode word not loaded");
	AST_VOLT_NIBBLE: assert property (o_set.volt[3:0] == 4'h0)
		else $error("voltage low bits not ignored");
	AST_ALARM_SET: assert property (commit && cmd_reg == `CHG_CMD_ALARM && batt |=> o_alarm_inh)
		else $error("alarm inhibit not set");
	AST_NINE_CLOCKS: assert property ($rose(ack_reg) |-> $past(cnt_reg) == 4'h8)
		else $error("acknowledge slot not after eight bits");
	AST_READ_NEEDS_STATUS: assert property (byte_end && state_reg == ST_ADDR && addr_hit && is_read && !rd_ok
		|=> o_sda_oe)
		else $error("read acknowledged without status command");
	AST_PWM_PERIOD: assert property (pwm_tick |=> pwm_cnt_reg == 9'h000 ##1 pwm_cnt_reg == 9'h001)
		else $error("converter period not restarted");
	AST_SR_ZERO_OFF: assert property (zero_s2_reg |=> !o_ls_gate)
		else $error("rectifier on after zero current");
endmodule

// >>> dv/chg_master_model.sv
// two-wire bus master model for the charger slave
`timescale 1ns/1ps
module chg_master_model (
	output logic o_scl,
	output logic o_sda,
	input wire logic i_sda
);
	// quarter of the 125 ns link period; clock stands high between frames
	realtime q = 31.25;
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic bit_io(input logic b, output logic r);
		o_sda = b;
		#q o_scl = 1'b1;
		#q r = i_sda;
		#q o_scl = 1'b0;
		#q;
	endtask
	task automatic start_c();
		o_sda = 1'b1;
		#q o_scl = 1'b1;
		#q o_sda = 1'b0;
		#q o_scl = 1'b0;
		#q;
	endtask
	task automatic stop_c();
		o_sda = 1'b0;
		#q o_scl = 1'b1;
		#q o_sda = 1'b1;
		#q;
	endtask
	// ak = 1 releases the line so the slave may answer
	task automatic byte_io(input logic [7:0] d, input logic ak, output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r[i]);
		end
		bit_io(ak, a);
	endtask
	task automatic wr_word(input logic [7:0] ad, input logic [7:0] cmd, input logic [15:0] w, output logic [3:0] nk);
		logic [7:0] r;
		start_c();
		byte_io(ad, 1'b1, r, nk[3]);
		byte_io(cmd, 1'b1, r, nk[2]);
		byte_io(w[7:0], 1'b1, r, nk[1]);
		byte_io(w[15:8], 1'b1, r, nk[0]);
		stop_c();
	endtask
	task automatic rd_word(output logic [15:0] w, output logic [2:0] nk);
		logic [7:0] r;
		logic a;
		start_c();
		byte_io(8'h12, 1'b1, r, nk[2]);
		byte_io(8'h13, 1'b1, r, nk[1]);
		start_c();
		byte_io(8'h13, 1'b1, r, nk[0]);
		byte_io(8'hFF, 1'b0, w[7:0], a);
		byte_io(8'hFF, 1'b1, w[15:8], a);
		stop_c();
	endtask
endmodule

// >>> dv/chg_smbus_slave_bench.sv
// self-checking bench for the charger two-wire slave
`timescale 1ns/1ps
module chg_smbus_slave_bench;
	import chg_pkg::*;
	logic i_clk = 1'b0;
	logic i_srst = 1'b1;
	logic [15:0] i_status = 16'h0000;
	logic [8:0] i_duty = 9'h000;
	logic i_zero_current = 1'b0;
	logic scl, m_sda, o_sda, o_sda_oe, o_alarm_inh, o_hs_gate, o_ls_gate;
	chg_setpoints_t o_set;
	// open-drain wire with pull-up: low if either party pulls
	wire sda_w = m_sda & (o_sda_oe | o_sda);
	int bad_count = 0;
	int compares = 0;
	logic [31:0] rs = 32'h00005BD1;
	always #5 i_clk = ~i_clk;
	chg_master_model m_u (.o_scl(scl), .o_sda(m_sda), .i_sda(sda_w));
	chg_smbus_slave dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_scl(scl), .i_sda(sda_w), .i_status(i_status),
		.i_duty(i_duty), .i_zero_current(i_zero_current), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_set(o_set),
		.o_alarm_inh(o_alarm_inh), .o_hs_gate(o_hs_gate), .o_ls_gate(o_ls_gate));
	function automatic logic [15:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs[15:0];
	endfunction
	function automatic logic [15:0] exp_stat(input logic [15:0] s, input logic al);
		return {s[15:4], al, s[2:0]};
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		logic [15:0] d, m, w;
		logic [3:0] nk;
		logic [2:0] rk;
		int hs, ls;
		cyc(20);
		i_srst <= 1'b0;
		cyc(4);
		chk(o_set.mode, 16'hFFD0);
		chk(o_set.volt, 16'h47F0);
		chk(o_set.curr, 16'h0007);
		chk({15'h0, o_alarm_inh}, 16'h0000);
		i_status <= rnd() | 16'h4000;
		cyc(6);
		// mode with thermal stop and reset bits clear, so forcing shows later
		m = rnd() & 16'hFBFB;
		m_u.wr_word(8'h12, 8'h12, m, nk);
		cyc(8);
		chk({12'h0, nk}, 16'h0000);
		chk(o_set.mode, m);
		d = rnd();
		m_u.wr_word(8'h12, 8'h15, d, nk);
		cyc(8);
		chk(o_set.volt, d & 16'hFFF0);
		d = rnd();
		m_u.wr_word(8'h12, 8'h14, d, nk);
		cyc(8);
		chk(o_set.curr, d);
		m_u.wr_word(8'h12, 8'h16, rnd(), nk);
		cyc(8);
		chk({15'h0, o_alarm_inh}, 16'h0001);
		m_u.rd_word(w, rk);
		chk({13'h0, rk}, 16'h0000);
		chk(w, exp_stat(i_status, 1'b1));
		for (int k = 0; k < 4; k++) begin
			d = rnd() & 16'h00FE;
			if (d[7:1] == 7'h09) begin
				d[7] = 1'b1;
			end
			m_u.wr_word(d[7:0], 8'h12, 16'h0000, nk);
			chk({12'h0, nk}, 16'h000F);
		end
		chk(o_set.mode, m);
		m_u.wr_word(8'h12, 8'h12, 16'hFFD4, nk);
		cyc(8);
		chk(o_set.volt, 16'hFFF0);
		chk(o_set.curr, 16'h0007);
		chk({15'h0, o_alarm_inh}, 16'h0000);
		// last command was a mode write, so a bare read address must be refused
		m_u.wr_word(8'h13, 8'h12, 16'h0000, nk);
		cyc(8);
		chk({12'h0, nk}, 16'h000F);
		chk(o_set.mode, 16'hFFD4);
		m_u.wr_word(8'h12, 8'h12, m, nk);
		cyc(8);
		i_status <= 16'h0000;
		cyc(6);
		chk(o_set.mode, m | 16'h0400);
		chk(o_set.volt, 16'h47F0);
		// duty kept above a few cycles so the wrap never opens the rectifier
		d = 16'h0008 + (rnd() % 16'h0180);
		i_duty <= d[8:0];
		cyc(810);
		hs = 0;
		ls = 0;
		repeat (400) begin
			@(posedge i_clk);
			hs += o_hs_gate;
			ls += o_ls_gate;
		end
		chk(hs[15:0], d);
		chk(ls[15:0], 16'h0190 - d);
		i_zero_current <= 1'b1;
		cyc(810);
		ls = 0;
		repeat (400) begin
			@(posedge i_clk);
			ls += o_ls_gate;
		end
		chk(ls[15:0], 16'h0000);
		final_report();
	end
	initial begin
		repeat (60000) @(posedge i_clk);
		bad_count++;
		final_report();
	end
endmodule
